/* rtl/prm_pkg.sv */
// Package for the peripheral pin remap fabric: register map, field layout and reset values.
// Assumes a 32-bit Avalon-MM slave port with word addresses.
package prm_pkg;
  localparam int          PRM_SEL_W        = 4;
  localparam int          PRM_ADDR_W       = 6;
  // Word addresses of the register map.
  localparam logic [5:0]  PRM_CFG_ADDR     = 6'h00;
  localparam logic [5:0]  PRM_UNLOCK_ADDR  = 6'h01;
  localparam logic [5:0]  PRM_STATUS_ADDR  = 6'h02;
  localparam logic [5:0]  PRM_IN_BASE      = 6'h10;
  localparam logic [5:0]  PRM_OUT_BASE     = 6'h20;
  // Field positions.
  localparam int          PRM_LOCK_BIT     = 13;
  localparam int          PRM_FUSE_BIT     = 29;
  localparam int          PRM_ARMED_BIT    = 0;
  localparam int          PRM_STAT_LOCK    = 1;
  localparam int          PRM_STAT_FUSE    = 2;
  // Reset values.
  localparam logic [3:0]  PRM_SEL_RST      = 4'h0;
  localparam logic        PRM_LOCK_RST     = 1'b0;
  // Two-word unlock key written to the unlock register; both values are arbitrary.
  localparam logic [31:0] PRM_KEY1         = 32'h0000C35A;
  localparam logic [31:0] PRM_KEY2         = 32'h00005AC3;
  typedef enum logic [1:0] {PRM_LOCKED, PRM_KEY1_SEEN, PRM_ARMED} prm_unlock_type;
endpackage

/* rtl/prm_remap.sv */
// Peripheral pin remap fabric: input and output selection, mapping lock and unlock sequencing.
// Assumes pins and peripherals are on clk, pad analog control sits outside, and an
// Avalon-MM master drives the register port.
//
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module prm_remap
  import prm_pkg::*;
#(
  parameter int   NPINS     = 15,
  parameter int   NIN       = 8,
  parameter int   NOUT      = 15,
  parameter logic FUSE_DFLT = 1'b1
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [prm_pkg::PRM_ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic                      single_session_lock_fuse_n,
  input  wire logic [NPINS-1:0]          pin_in,
  input  wire logic [NPINS-1:0]          pin_analog,
  input  wire logic [NPINS-1:0]          pin_default_out,
  input  wire logic [NPINS-1:0]          pin_default_oe,
  output logic      [NPINS-1:0]          pin_out,
  output logic      [NPINS-1:0]          pin_oe,
  input  wire logic [NOUT-1:0]           periph_out,
  input  wire logic [NOUT-1:0]           periph_oe,
  output logic      [NIN-1:0]            periph_in
);
  import prm_pkg::*;

  logic [PRM_SEL_W-1:0] in_sel_q  [NIN];
  logic [PRM_SEL_W-1:0] in_sel_d  [NIN];
  logic [PRM_SEL_W-1:0] out_sel_q [NPINS];
  logic [PRM_SEL_W-1:0] out_sel_d [NPINS];
  logic                 lock_q, lock_d;
  logic                 fuse_q, fuse_d;
  logic                 fuse_cap_q, fuse_cap_d;
  logic                 ack_q, ack_d;
  logic [31:0]          rdata_q, rdata_d;
  prm_unlock_type       ul_q, ul_d;
  logic                 wr_go, rd_go;

  // Each access waits one cycle. A write lands on the edge that sees waitrequest low,
  // so a write that is still in its wait state has not yet changed any state.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_go = avs_write & ack_q;
  assign rd_go = avs_read & ~ack_q;
  assign avs_readdata = rdata_q;

  always_comb begin
    in_sel_d   = in_sel_q;
    out_sel_d  = out_sel_q;
    lock_d     = lock_q;
    fuse_d     = fuse_q;
    fuse_cap_d = 1'b1;
    ul_d       = ul_q;
    ack_d      = (avs_read | avs_write) & ~ack_q;
    rdata_d    = rdata_q;
    // The fuse strap is sampled once, on the first clock after reset release.
    if (!fuse_cap_q) begin
      fuse_d = FUSE_DFLT & ~single_session_lock_fuse_n;
    end
    if (wr_go && avs_byteenable == 4'hF) begin
      if (avs_address == PRM_UNLOCK_ADDR) begin
        unique case (ul_q)
          PRM_LOCKED:    ul_d = (avs_writedata == PRM_KEY1) ? PRM_KEY1_SEEN : PRM_LOCKED;
          PRM_KEY1_SEEN: ul_d = (avs_writedata == PRM_KEY2) ? PRM_ARMED : PRM_LOCKED;
          PRM_ARMED:     ul_d = PRM_ARMED;
        endcase
      end else if (avs_address == PRM_CFG_ADDR) begin
        // The unlock is consumed by any full-word write to the control word.
        ul_d = PRM_LOCKED;
        // Setting is always honoured once armed. Clearing is refused while the fuse holds a
        // set lock, so a fused lock is freed only by reset.
        if (ul_q == PRM_ARMED) begin
          if (avs_writedata[PRM_LOCK_BIT]) begin
            lock_d = 1'b1;
          end else if (!(fuse_q && lock_q)) begin
            lock_d = 1'b0;
          end
        end
      end else if (!lock_q) begin
        for (int i = 0; i < NIN; i++) begin
          if (avs_address == PRM_IN_BASE + 6'(i)) begin
            in_sel_d[i] = avs_writedata[PRM_SEL_W-1:0];
          end
        end
        for (int i = 0; i < NPINS; i++) begin
          if (avs_address == PRM_OUT_BASE + 6'(i)) begin
            out_sel_d[i] = avs_writedata[PRM_SEL_W-1:0];
          end
        end
      end
    end
    if (rd_go) begin
      rdata_d = 32'h00000000;
      if (avs_address == PRM_CFG_ADDR) begin
        rdata_d[PRM_LOCK_BIT] = lock_q;
      end else if (avs_address == PRM_STATUS_ADDR) begin
        rdata_d[PRM_ARMED_BIT] = (ul_q == PRM_ARMED);
        rdata_d[PRM_STAT_LOCK] = lock_q;
        rdata_d[PRM_STAT_FUSE] = fuse_q;
      end else begin
        for (int i = 0; i < NIN; i++) begin
          if (avs_address == PRM_IN_BASE + 6'(i)) begin
            rdata_d[PRM_SEL_W-1:0] = in_sel_q[i];
          end
        end
        for (int i = 0; i < NPINS; i++) begin
          if (avs_address == PRM_OUT_BASE + 6'(i)) begin
            rdata_d[PRM_SEL_W-1:0] = out_sel_q[i];
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NIN; i++) begin
        in_sel_q[i] <= PRM_SEL_RST;
      end
      for (int i = 0; i < NPINS; i++) begin
        out_sel_q[i] <= PRM_SEL_RST;
      end
      lock_q     <= PRM_LOCK_RST;
      fuse_q     <= 1'b1;
      fuse_cap_q <= 1'b0;
      ul_q       <= PRM_LOCKED;
      ack_q      <= 1'b0;
      rdata_q    <= 32'h00000000;
    end else begin
      in_sel_q   <= in_sel_d;
      out_sel_q  <= out_sel_d;
      lock_q     <= lock_d;
      fuse_q     <= fuse_d;
      fuse_cap_q <= fuse_cap_d;
      ul_q       <= ul_d;
      ack_q      <= ack_d;
      rdata_q    <= rdata_d;
    end
  end

  // Separate input and output select sets drive independent muxes. Only digital-only
  // peripherals are wired to periph_in and periph_out by the integrator.
  genvar g;
  generate
    for (g = 0; g < NIN; g++) begin : g_in
      // A select pointing past the pin count reads zero.
      assign periph_in[g] = (int'(in_sel_q[g]) < NPINS) ? pin_in[in_sel_q[g]] : 1'b0;
      // Every input select is guarded, not only the first one.
      in_far_a: assert property (@(posedge clk) disable iff (!rst_n)
        (int'(in_sel_q[g]) >= NPINS) |-> !periph_in[g])
        else $error("Input select past the pins gave a value.");
      in_locked_a: assert property (@(posedge clk) disable iff (!rst_n)
        lock_q |=> $stable(in_sel_q[g]))
        else $error("Input select changed while locked.");
    end
    for (g = 0; g < NPINS; g++) begin : g_pin
      logic act;
      logic [PRM_SEL_W-1:0] s;
      assign s   = out_sel_q[g];
      // Code zero is the null output; code k selects peripheral output k-1.
      assign act = (s != 4'h0) && (int'(s) <= NOUT) && !pin_analog[g];
      assign pin_out[g] = act ? periph_out[int'(s) - 1] : pin_default_out[g];
      assign pin_oe[g]  = pin_analog[g] ? 1'b0 :
                          act ? periph_oe[int'(s) - 1] : pin_default_oe[g];
      // Every pin is guarded, not only the first one.
      pin_null_a: assert property (@(posedge clk) disable iff (!rst_n)
        (out_sel_q[g] == 4'h0 && !pin_analog[g])
          |-> (pin_out[g] == pin_default_out[g] && pin_oe[g] == pin_default_oe[g]))
        else $error("Null select changed a pin.");
      pin_analog_a: assert property (@(posedge clk) disable iff (!rst_n)
        pin_analog[g] |-> (!pin_oe[g] && pin_out[g] == pin_default_out[g]))
        else $error("Remapped output overrode analog.");
      pin_locked_a: assert property (@(posedge clk) disable iff (!rst_n)
        lock_q |=> $stable(out_sel_q[g]))
        else $error("Output select changed while locked.");
    end
  endgenerate

  lock_blocks_a: assert property (@(posedge clk) disable iff (!rst_n)
    lock_q |=> $stable(out_sel_q[0]) && $stable(in_sel_q[0]))
    else $error("Select changed while locked.");
  fuse_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fuse_q && lock_q && fuse_cap_q) |=> lock_q)
    else $error("Lock cleared under fuse.");
  unlock_need_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ul_q != PRM_ARMED) |=> $stable(lock_q))
    else $error("Lock changed without unlock.");
  null_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    (out_sel_q[0] == 4'h0) |-> (pin_out[0] == pin_default_out[0]))
    else $error("Null select drove pin.");
  analog_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    pin_analog[0] |-> !pin_oe[0])
    else $error("Pin driven over analog.");
  in_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    (in_sel_q[0] == 4'h1) |-> (periph_in[0] == pin_in[1]))
    else $error("Input route wrong.");
  out_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    (out_sel_q[0] == 4'h1 && !pin_analog[0]) |-> (pin_out[0] == periph_out[0]))
    else $error("Output route wrong.");
  sel_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_go && !lock_q && avs_byteenable == 4'hF && avs_address == PRM_OUT_BASE)
      |=> (out_sel_q[0] == $past(avs_writedata[3:0])))
    else $error("Select write not taken.");
  bus_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
    (avs_read || avs_write) && !ack_q |=> !avs_waitrequest)
    else $error("Access not answered in one cycle.");

  // The unlock is a chain of full-word writes; each step is a named sequence.
  sequence key1_write_s;
    wr_go && avs_byteenable == 4'hF && avs_address == PRM_UNLOCK_ADDR
      && ul_q == PRM_LOCKED && avs_writedata == PRM_KEY1;
  endsequence
  sequence key2_write_s;
    wr_go && avs_byteenable == 4'hF && avs_address == PRM_UNLOCK_ADDR
      && ul_q == PRM_KEY1_SEEN && avs_writedata == PRM_KEY2;
  endsequence
  sequence key_wrong_s;
    wr_go && avs_byteenable == 4'hF && avs_address == PRM_UNLOCK_ADDR
      && ul_q == PRM_KEY1_SEEN && avs_writedata != PRM_KEY2;
  endsequence
  sequence cfg_write_s;
    wr_go && avs_byteenable == 4'hF && avs_address == PRM_CFG_ADDR;
  endsequence
  sequence armed_set_s;
    cfg_write_s ##0 (ul_q == PRM_ARMED && avs_writedata[PRM_LOCK_BIT]);
  endsequence
  sequence armed_clear_s;
    cfg_write_s ##0 (ul_q == PRM_ARMED && !avs_writedata[PRM_LOCK_BIT] && !fuse_q);
  endsequence

  key_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    key1_write_s |=> (ul_q == PRM_KEY1_SEEN))
    else $error("First key word not taken.");
  key_second_a: assert property (@(posedge clk) disable iff (!rst_n)
    key2_write_s |=> (ul_q == PRM_ARMED))
    else $error("Second key word did not arm.");
  key_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
    key_wrong_s |=> (ul_q == PRM_LOCKED))
    else $error("Wrong key word did not restart.");
  unlock_used_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_write_s |=> (ul_q == PRM_LOCKED))
    else $error("Unlock not consumed by control write.");
  lock_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    armed_set_s |=> lock_q)
    else $error("Armed write did not set the lock.");
  lock_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    armed_clear_s |=> !lock_q)
    else $error("Armed write did not clear the lock.");
  fuse_take_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_n && !fuse_cap_q) |=> (fuse_q == (FUSE_DFLT & ~$past(single_session_lock_fuse_n))))
    else $error("Fuse strap not captured.");
  partial_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_go && avs_byteenable != 4'hF) |=> ($stable(lock_q) && $stable(ul_q)))
    else $error("Partial write changed state.");

  // Read data is loaded in the wait cycle and stands until the next read.
  read_stand_a: assert property (@(posedge clk) disable iff (!rst_n)
    !rd_go |=> $stable(avs_readdata))
    else $error("Read data moved without a read.");
  read_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_go && avs_address == PRM_CFG_ADDR) |=> (avs_readdata[PRM_LOCK_BIT] == $past(lock_q)))
    else $error("Control word read wrong.");
  read_status_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_go && avs_address == PRM_STATUS_ADDR)
      |=> (avs_readdata[PRM_STAT_FUSE] == $past(fuse_q)
           && avs_readdata[PRM_STAT_LOCK] == $past(lock_q)))
    else $error("Status read wrong.");
  read_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_go && avs_address == PRM_IN_BASE) |=> (avs_readdata == {28'h0, $past(in_sel_q[0])}))
    else $error("Select read-back wrong.");
  ack_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    ack_q |=> !ack_q)
    else $error("Answer lasted more than one cycle.");
endmodule // prm_remap

`default_nettype wire

/* verification/prm_far_model.sv */
// Pad and peripheral model around the remap fabric.
// Assumes the remap fabric samples these lines on the same rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module prm_far_model (
  input  wire logic        clk,
  output logic      [14:0] pin_in,
  output logic      [14:0] pin_analog,
  output logic      [14:0] pin_default_out,
  output logic      [14:0] pin_default_oe,
  output logic      [14:0] periph_out,
  output logic      [14:0] periph_oe
);
  logic [63:0] st_q = 64'h0123_4567_89AB_CDEF;
  // All lines come from one LFSR that shifts each cycle, so a stale route seldom matches by luck.
  always_ff @(posedge clk) begin
    st_q <= {st_q[62:0], st_q[63] ^ st_q[62] ^ st_q[60] ^ st_q[59]};
  end
  assign pin_in          = st_q[14:0];
  assign pin_analog      = st_q[29:15] & st_q[44:30] & st_q[59:45];
  assign pin_default_out = st_q[44:30];
  assign pin_default_oe  = st_q[59:45];
  assign periph_out      = st_q[22:8];
  assign periph_oe       = st_q[37:23];
endmodule // prm_far_model
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the remap fabric with a select and lock model.
// Assumes the far model drives pads and peripherals; byteenable is full but for one write per session.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import prm_pkg::*;
  logic        clk = 0, rst_n = 0, rd = 0, wr = 0, fuse_n = 0, wreq;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wd = 32'h0, rdata, lfsr = 32'hBC78;
  logic [3:0]  be = 4'hF;
  logic [14:0] pi, pa, pdo, pdoe, po, poe, fo, foe;
  logic [7:0]  fi;
  int          n_mismatch = 0, samples_checked = 0;
  int          isel [8];
  int          osel [15];
  initial forever #20 clk = ~clk;
  prm_far_model u_far (.clk(clk), .pin_in(pi), .pin_analog(pa), .pin_default_out(pdo),
    .pin_default_oe(pdoe), .periph_out(fo), .periph_oe(foe));
  prm_remap u_dut (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .single_session_lock_fuse_n(fuse_n), .pin_in(pi),
    .pin_analog(pa), .pin_default_out(pdo), .pin_default_oe(pdoe), .pin_out(po),
    .pin_oe(poe), .periph_out(fo), .periph_oe(foe), .periph_in(fi));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // The request is held until the edge that sees waitrequest low.
  task automatic bus(logic w, logic [5:0] a, logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      t++;
    end while (wreq !== 1'b0 && t < 50);
    rd <= 1'b0;
    wr <= 1'b0;
    if (t >= 50) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task automatic rdchk(string nm, logic [5:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rdata);
  endtask
  task automatic unlock(logic [31:0] v);
    bus(1'b1, PRM_UNLOCK_ADDR, PRM_KEY1);
    bus(1'b1, PRM_UNLOCK_ADDR, PRM_KEY2);
    bus(1'b1, PRM_CFG_ADDR, v);
  endtask
  task automatic pins();
    logic [14:0] eo, ee;
    logic [7:0]  ei;
    @(negedge clk);
    for (int p = 0; p < 15; p++) begin
      eo[p] = (osel[p] != 0 && !pa[p]) ? fo[osel[p]-1] : pdo[p];
      ee[p] = (osel[p] != 0) ? foe[osel[p]-1] : pdoe[p];
      if (pa[p]) ee[p] = 1'b0;
    end
    for (int i = 0; i < 8; i++) ei[i] = (isel[i] < 15) ? pi[isel[i]] : 1'b0;
    chk("pin_oe", 32'(ee), 32'(poe));
    chk("pin_out", 32'(eo), 32'(po));
    chk("periph_in", 32'(ei), 32'(fi));
  endtask
  task automatic session(logic prog);
    logic [31:0] v;
    logic [5:0]  a;
    foreach (isel[i]) isel[i] = 0;
    foreach (osel[p]) osel[p] = 0;
    rdchk("status", PRM_STATUS_ADDR, {29'h0, !prog, 2'b00});
    rdchk("config", PRM_CFG_ADDR, 32'h0);
    for (int p = 0; p < 15; p++) rdchk("out_sel", 6'(PRM_OUT_BASE + p), 32'h0);
    pins();
    // A write with a partial byteenable is refused.
    @(posedge clk);
    be <= 4'h1;
    bus(1'b1, PRM_OUT_BASE, 32'h5);
    be <= 4'hF;
    rdchk("partial", PRM_OUT_BASE, 32'h0);
    bus(1'b1, PRM_CFG_ADDR, 32'h2000);
    rdchk("config", PRM_CFG_ADDR, 32'h0);
    for (int i = 0; i < 23; i++) begin
      v = rnd();
      a = 6'((i < 8) ? PRM_IN_BASE + i : PRM_OUT_BASE + i - 8);
      if (i < 8) isel[i] = v[3:0];
      else osel[i-8] = v[3:0];
      bus(1'b1, a, v);
      rdchk("sel", a, {28'h0, v[3:0]});
      pins();
    end
    // A broken key sequence must leave the lock alone.
    bus(1'b1, PRM_UNLOCK_ADDR, PRM_KEY1);
    bus(1'b1, PRM_UNLOCK_ADDR, 32'h0);
    bus(1'b1, PRM_UNLOCK_ADDR, PRM_KEY2);
    bus(1'b1, PRM_CFG_ADDR, 32'h2000);
    rdchk("config", PRM_CFG_ADDR, 32'h0);
    bus(1'b1, PRM_UNLOCK_ADDR, PRM_KEY1);
    bus(1'b1, PRM_UNLOCK_ADDR, PRM_KEY2);
    rdchk("armed", PRM_STATUS_ADDR, {29'h0, !prog, 2'b01});
    bus(1'b1, PRM_CFG_ADDR, 32'h2000);
    rdchk("config", PRM_CFG_ADDR, 32'h2000);
    bus(1'b1, PRM_OUT_BASE, 32'(osel[0] ^ 1));
    bus(1'b1, PRM_IN_BASE, 32'(isel[0] ^ 1));
    rdchk("locked_out", PRM_OUT_BASE, 32'(osel[0]));
    rdchk("locked_in", PRM_IN_BASE, 32'(isel[0]));
    pins();
    unlock(32'h0);
    rdchk("config", PRM_CFG_ADDR, prog ? 32'h0 : 32'h2000);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    session(1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    fuse_n <= 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    session(1'b1);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
